// file: rtl/ssb_pkg.sv
package ssb_pkg;
    localparam logic [7:0] REG_FAMILY_OFS   = 8'h00;
    localparam logic [7:0] REG_REVRUN_OFS   = 8'h01;
    localparam int         IDENT_HI         = 7;
    localparam int         IDENT_LO         = 4;
    localparam int         REV_HI           = 3;
    localparam int         REV_LO           = 1;
    localparam int         START_BIT        = 0;
    localparam logic       START_RESET      = 1'b0;
    localparam int         CLK_MHZ          = 40;
    localparam int         CFG_WAIT_US      = 100;
    localparam int         CFG_WAIT_CYCLES  = CFG_WAIT_US * CLK_MHZ;
    localparam logic [1:0] STRAP_AUTO       = 2'b00;
    localparam logic [1:0] STRAP_HOST_B     = 2'b01;
    localparam logic [1:0] STRAP_HOST_SLAVE = 2'b10;
    localparam logic [1:0] STRAP_FACTORY    = 2'b11;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssb_req_t;

    typedef struct packed {
        logic       req;
        logic [7:0] addr;
    } ssb_eep_req_t;

    typedef struct packed {
        logic       ack;
        logic       absent;
        logic [7:0] data;
    } ssb_eep_rsp_t;
endpackage

// file: rtl/ssb_ident_check.sv
module ssb_ident_check
    import ssb_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
    parameter logic [3:0] IDENT_MII   = 4'h3,  // arbitrary value
    parameter logic [3:0] IDENT_RMII  = 4'h7   // arbitrary value
) (
    input  wire logic [7:0] image_family,
    input  wire logic [7:0] image_revrun,
    output logic            image_ok
);
    import ssb_pkg::*;
    always_comb begin
        image_ok = (image_family == FAMILY_CODE) &&
                   ((image_revrun[IDENT_HI:IDENT_LO] == IDENT_MII) ||
                    (image_revrun[IDENT_HI:IDENT_LO] == IDENT_RMII));
    end
endmodule

// file: rtl/ssb_top.sv
// Contract
// - strap 10: start only after start write
// - strap 00: self start after eeprom attempt
// - no eeprom: run with defaults
// - image must hold family and chip identity
// - load image only after identity passes
// - start bit zero keeps 10/01 stopped
// - writing zero halts switching for straps 10/01; strap 00 keeps running
// - identity differs in port four rmii
// - start clear after reset; 100us wait
module ssb_top
    import ssb_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE   = 8'h5a, // arbitrary value
    parameter logic [3:0] IDENT_MII     = 4'h3,  // arbitrary value
    parameter logic [3:0] IDENT_RMII    = 4'h7,  // arbitrary value
    parameter logic [2:0] REVISION      = 3'h5,  // arbitrary value
    parameter int         WAIT_CYCLES   = CFG_WAIT_CYCLES
) (
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire logic                strap_select_hi,
    input  wire logic                strap_select_lo,
    input  wire logic                port4_rmii,
    input  ssb_pkg::ssb_req_t        host_req,
    output logic [7:0]               host_rdata,
    output logic                     host_rvalid,
    output ssb_pkg::ssb_eep_req_t    eep_req,
    input  ssb_pkg::ssb_eep_rsp_t    eep_rsp,
    output logic                     load_image,
    output logic [7:0]               load_family,
    output logic [7:0]               load_revrun,
    output logic                     use_defaults,
    output logic                     boot_done,
    output logic                     cfg_ready,
    output logic                     switch_run
);
    import ssb_pkg::*;

    typedef enum logic [2:0] {
        ST_STRAP, ST_RD0, ST_RD1, ST_CHECK, ST_RUN_AUTO, ST_HOST
    } ssb_state_t;

    logic              rst_s1;
    logic              rst_n;
    ssb_state_t        state;
    ssb_state_t        next_state;
    logic [1:0]        strap;
    logic [1:0]        next_strap;
    logic [7:0]        img0;
    logic [7:0]        next_img0;
    logic [7:0]        img1;
    logic [7:0]        next_img1;
    logic              start;
    logic              next_start;
    logic              done;
    logic              next_done;
    logic              load;
    logic              next_load;
    logic              dflt;
    logic              next_dflt;
    logic [7:0]        rdata;
    logic [7:0]        next_rdata;
    logic              rvalid;
    logic              next_rvalid;
    logic [31:0]       wait_cnt;
    logic [31:0]       next_wait_cnt;
    logic              image_ok;
    logic [3:0]        ident;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    ssb_ident_check #(
        .FAMILY_CODE (FAMILY_CODE),
        .IDENT_MII   (IDENT_MII),
        .IDENT_RMII  (IDENT_RMII)
    ) u_check (
        .image_family (img0),
        .image_revrun (img1),
        .image_ok     (image_ok)
    );

    assign ident = port4_rmii ? IDENT_RMII : IDENT_MII;

    always_comb begin
        next_state    = state;
        next_strap    = strap;
        next_img0     = img0;
        next_img1     = img1;
        next_start    = start;
        next_done     = done;
        next_load     = 1'b0;
        next_dflt     = dflt;
        next_rdata    = rdata;
        next_rvalid   = 1'b0;
        next_wait_cnt = wait_cnt;
        if (wait_cnt < WAIT_CYCLES) begin
            next_wait_cnt = wait_cnt + 32'd1;
        end
        case (state)
            ST_STRAP: begin
                next_strap = {strap_select_hi, strap_select_lo};
                if ({strap_select_hi, strap_select_lo} == STRAP_AUTO) begin
                    next_state = ST_RD0;
                end else begin
                    next_state = ST_HOST;
                    next_done  = 1'b1;
                end
            end
            ST_RD0: begin
                if (eep_rsp.ack) begin
                    if (eep_rsp.absent) begin
                        next_dflt  = 1'b1;
                        next_state = ST_RUN_AUTO;
                    end else begin
                        next_img0  = eep_rsp.data;
                        next_state = ST_RD1;
                    end
                end
            end
            ST_RD1: begin
                if (eep_rsp.ack) begin
                    if (eep_rsp.absent) begin
                        next_dflt  = 1'b1;
                        next_state = ST_RUN_AUTO;
                    end else begin
                        next_img1  = eep_rsp.data;
                        next_state = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                if (image_ok) begin
                    next_load = 1'b1;
                    next_dflt = 1'b0;
                end else begin
                    next_dflt = 1'b1;
                end
                next_state = ST_RUN_AUTO;
            end
            ST_RUN_AUTO: begin
                next_done = 1'b1;
            end
            ST_HOST: begin
                next_done = 1'b1;
            end
            default: begin
                next_state = ST_STRAP;
            end
        endcase
        if (host_req.rd) begin
            next_rvalid = 1'b1;
            case (host_req.addr)
                REG_FAMILY_OFS: next_rdata = FAMILY_CODE;
                REG_REVRUN_OFS: next_rdata = {ident, REVISION, start};
                default:        next_rdata = 8'h00;
            endcase
        end
        if (host_req.wr && host_req.addr == REG_REVRUN_OFS) begin
            next_start = host_req.wdata[START_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_STRAP;
            strap    <= STRAP_FACTORY;
            img0     <= 8'h00;
            img1     <= 8'h00;
            start    <= START_RESET;
            done     <= 1'b0;
            load     <= 1'b0;
            dflt     <= 1'b0;
            rdata    <= 8'h00;
            rvalid   <= 1'b0;
            wait_cnt <= 32'd0;
        end else begin
            state    <= next_state;
            strap    <= next_strap;
            img0     <= next_img0;
            img1     <= next_img1;
            start    <= next_start;
            done     <= next_done;
            load     <= next_load;
            dflt     <= next_dflt;
            rdata    <= next_rdata;
            rvalid   <= next_rvalid;
            wait_cnt <= next_wait_cnt;
        end
    end

    always_comb begin
        eep_req.req  = (state == ST_RD0) || (state == ST_RD1);
        eep_req.addr = (state == ST_RD1) ? REG_REVRUN_OFS : REG_FAMILY_OFS;
        case (state)
            ST_RUN_AUTO: switch_run = start || (strap == STRAP_AUTO);
            ST_HOST:     switch_run = start && (strap != STRAP_FACTORY);
            default:     switch_run = 1'b0;
        endcase
    end

    assign host_rdata   = rdata;
    assign host_rvalid  = rvalid;
    assign load_image   = load;
    assign load_family  = img0;
    assign load_revrun  = img1;
    assign use_defaults = dflt;
    assign boot_done    = done;
    assign cfg_ready    = (wait_cnt >= WAIT_CYCLES);
endmodule

// file: bench/ssb_assertions.sv
module ssb_assertions
    import ssb_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
    parameter logic [3:0] IDENT_MII   = 4'h3,  // arbitrary value
    parameter logic [3:0] IDENT_RMII  = 4'h7   // arbitrary value
) (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        strap_select_hi,
    input wire logic        strap_select_lo,
    input wire logic        port4_rmii,
    input ssb_pkg::ssb_req_t     host_req,
    input wire logic [7:0]  host_rdata,
    input wire logic        host_rvalid,
    input ssb_pkg::ssb_eep_req_t eep_req,
    input ssb_pkg::ssb_eep_rsp_t eep_rsp,
    input wire logic        load_image,
    input wire logic [7:0]  load_family,
    input wire logic        use_defaults,
    input wire logic        boot_done,
    input wire logic        switch_run
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire logic hs = strap_select_hi ^ strap_select_lo;
    wire logic w1 = host_req.wr && host_req.addr == 8'h01;
    AST_IDENT: assert property (host_req.rd && host_req.addr == 8'h01 |=> host_rvalid &&
        host_rdata[7:4] == (port4_rmii ? IDENT_RMII : IDENT_MII)) else $error("bad ident");
    AST_START: assert property (hs && w1 && host_req.wdata[0] |=> switch_run) else $error("no start");
    AST_HALT: assert property (hs && w1 && !host_req.wdata[0] |=> !switch_run) else $error("no halt");
    AST_HOLD: assert property (hs && !switch_run && !w1 |=> !switch_run) else $error("self start");
    AST_FACT: assert property (strap_select_hi && strap_select_lo |-> !switch_run) else $error("runs");
    AST_AUTO: assert property (!strap_select_hi && !strap_select_lo && boot_done |-> switch_run)
        else $error("no auto run");
    AST_LOAD: assert property (load_image |-> load_family == FAMILY_CODE && !use_defaults)
        else $error("bad load");
    AST_ABS: assert property (eep_req.req && eep_rsp.ack && eep_rsp.absent |=> use_defaults)
        else $error("abs");
    cover property (load_image);
    cover property (use_defaults && switch_run);
    cover property (hs && $fell(switch_run));
endmodule

bind ssb_top ssb_assertions #(.FAMILY_CODE(FAMILY_CODE), .IDENT_MII(IDENT_MII), .IDENT_RMII(IDENT_RMII)) u_chk (
    .mclk, .rstn, .strap_select_hi, .strap_select_lo, .port4_rmii, .host_req, .host_rdata, .host_rvalid,
    .eep_req, .eep_rsp, .load_image, .load_family, .use_defaults, .boot_done, .switch_run);

// file: bench/ssb_eep_model.sv
module ssb_eep_model
    import ssb_pkg::*;
(
    input wire logic        mclk,
    input wire logic        present,
    input wire logic [2:0]  lag,
    input wire logic [15:0] image,
    input ssb_pkg::ssb_eep_req_t  eep_req,
    output ssb_pkg::ssb_eep_rsp_t eep_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    initial eep_rsp = '0;
    // data stands only in the ack cycle, then toggles
    always @(posedge mclk) begin
        eep_rsp.ack <= 1'b0;
        eep_rsp.absent <= !present;
        eep_rsp.data <= ~eep_rsp.data;
        n <= eep_req.req ? n + 1 : 0;
        if (eep_req.req && !eep_rsp.ack && n >= lag) begin
            eep_rsp.ack <= 1'b1;
            eep_rsp.data <= eep_req.addr[0] ? image[7:0] : image[15:8];
            n <= 0;
        end
    end
endmodule

// file: bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ssb_pkg::*;
    logic mclk = 0, rstn = 0, hi = 0, lo = 0, rmii = 0, pres = 1;
    logic [15:0] image = '0, lfsr = 16'h1ffa;
    logic [7:0] rdata, nld, fam, rvr;
    logic rv, ld, df, done, rdy, run;
    ssb_req_t req = '0;
    ssb_eep_req_t ereq;
    ssb_eep_rsp_t ersp;
    int err_total = 0, n_compared = 0, st = 0;
    logic [1:0] hs [3] = '{2'b10, 2'b01, 2'b11};
    always #12.5 mclk = ~mclk;
    always @(negedge mclk) if (ld === 1'b1) nld++;
    ssb_top #(.WAIT_CYCLES(20)) dut (.mclk, .rstn, .strap_select_hi(hi), .strap_select_lo(lo),
        .port4_rmii(rmii), .host_req(req), .host_rdata(rdata), .host_rvalid(rv), .eep_req(ereq),
        .eep_rsp(ersp), .load_image(ld), .load_family(fam), .load_revrun(rvr), .use_defaults(df),
        .boot_done(done), .cfg_ready(rdy), .switch_run(run));
    ssb_eep_model eep (.mclk, .present(pres), .lag(lfsr[2:0]), .image, .eep_req(ereq), .eep_rsp(ersp));
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic boot(logic [1:0] s);
        rstn = 0;
        {hi, lo} = s;
        repeat (6) @(negedge mclk);
        rstn = 1;
        nld = 0;
        st = 0;
        repeat (3) @(negedge mclk);
    endtask
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic op(logic r, logic [7:0] a, logic [7:0] d, logic [7:0] e);
        lfsr = lfsr_next(lfsr);
        req = '{r, !r, a, d};
        @(negedge mclk);
        req = '0;
        if (r) chk("rdata", e, rdata);
        if (r) chk("rvalid", 1, rv);
        if (!r && a == 8'h01) st = d[0];
        @(negedge mclk);
    endtask
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        boot(2'b10);
        chk("ready", 0, rdy);
        repeat (22) @(negedge mclk);
        chk("ready", 1, rdy);
        foreach (hs[i]) begin
            boot(hs[i]);
            rmii = i[0];
            repeat (20) @(negedge mclk);
            chk("ready", 1, rdy);
            op(1, 8'h00, 0, 8'h5a);
            op(1, 8'h01, 0, {rmii ? 4'h7 : 4'h3, 3'h5, 1'b0});
            op(0, lfsr[7:0] | 8'h02, 8'hff, 0);
            op(1, lfsr[7:0] | 8'h02, 0, 8'h00);
            chk("run", 0, run);
            op(0, 8'h01, {lfsr[7:1], 1'b1}, 0);
            chk("run", hs[i] != 2'b11, run);
            op(1, 8'h01, 0, {rmii ? 4'h7 : 4'h3, 3'h5, st[0]});
            op(0, 8'h01, 8'h00, 0);
            chk("run", 0, run);
        end
        for (int m = 0; m < 3; m++) begin
            pres = m != 2;
            image = {m == 1 ? 8'ha5 : 8'h5a, lfsr[3] ? 4'h7 : 4'h3, lfsr[7:4]};
            boot(2'b00);
            for (int k = 0; k < 100 && done !== 1'b1; k++) @(negedge mclk);
            chk("load", m == 0, nld);
            chk("defaults", m != 0, df);
            chk("run", 1, run);
            chk("done", 1, done);
            if (m == 0) chk("family", image[15:8], fam);
            if (m == 0) chk("revrun", image[7:0], rvr);
            lfsr = lfsr_next(lfsr);
        end
        summarize();
    end
    initial begin
        #200us;
        err_total++;
        summarize();
    end
endmodule
